/* hw/dmc_pkg.sv */
// Behaviour
// - Mode 4: active once stator exceeds threshold
// - Mode 4 releases below threshold minus delta
// - Output stages off force setting signal low
// - Threshold and delta 0..599.00 Hz, defaults 3/2
// - Delta above threshold keeps output latched on
// - Sources 164, 163, 178 offered for linking
// - Mode 5: actual frequency reached the setpoint
// - Mode 6: percentage reached, x11/x30 only
// - Hysteresis 0.01..20.00 % of range, default 5
// - Output signals exposed as 175-177, combinable
// - Extension outputs exposed as 181 and 182
// - Codes 100..194 give inverted, low-active modes
package dmc_pkg;
  // Frequencies in 0.01 Hz, percentages in 0.01 %
  typedef logic [15:0] dmc_val_t;
  typedef logic [7:0]  dmc_code_t;

  localparam dmc_val_t FREQ_MAX      = 16'hE9FC;
  localparam dmc_val_t SET_FREQ_RST  = 16'h012C;
  localparam dmc_val_t OFF_DELTA_RST = 16'h00C8;
  localparam dmc_val_t DEV_MIN       = 16'h0001;
  localparam dmc_val_t DEV_MAX       = 16'h07D0;
  localparam dmc_val_t DEV_RST       = 16'h01F4;
  localparam logic [31:0] PCT_SCALE  = 32'h0000_2710;

  localparam dmc_code_t MODE_OFF      = 8'h00;
  localparam dmc_code_t MODE_ON       = 8'h01;
  localparam dmc_code_t MODE_SETFREQ  = 8'h04;
  localparam dmc_code_t MODE_FREQ_RCH = 8'h05;
  localparam dmc_code_t MODE_PCT_RCH  = 8'h06;
  localparam dmc_code_t MODE_INV_BASE = 8'h64;
  localparam dmc_code_t MODE_INV_LAST = 8'hC2;

  localparam dmc_code_t SRC_NONE     = 8'h00;
  localparam dmc_code_t SRC_FREQ_RCH = 8'hA3;
  localparam dmc_code_t SRC_SETFREQ  = 8'hA4;
  localparam dmc_code_t SRC_DIG1     = 8'hAF;
  localparam dmc_code_t SRC_DIG2     = 8'hB0;
  localparam dmc_code_t SRC_DIG3     = 8'hB1;
  localparam dmc_code_t SRC_PCT_RCH  = 8'hB2;
  localparam dmc_code_t SRC_EXT1     = 8'hB5;
  localparam dmc_code_t SRC_EXT2     = 8'hB6;

  // Output order: digital 1, multifunction, relay, ext 1, ext 2
  localparam int NUM_OUT  = 5;
  localparam int OUT_EXT1 = 3;
  localparam int NUM_EVT  = 3;

  typedef struct packed {
    logic                 pctReached;
    logic                 freqReached;
    logic                 setFreq;
    logic [NUM_OUT-1:0]   digSig;
  } dmc_src_t;

  typedef struct packed {
    dmc_code_t link;
    dmc_code_t mode;
  } dmc_outcfg_t;

  localparam int ADDR_W   = 12;
  localparam int WORD_LSB = 2;
  localparam int IDX_W    = 3;
  localparam logic [ADDR_W-1:0] ADDR_OUT_CFG0 = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_SET_FREQ = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_OFF_DLT  = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_MAX_DEV  = 12'h01C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h024;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h028;
  localparam int TRANS_ACT = 1;
endpackage

/* hw/dmc_setfreq.sv */
`timescale 1ns/10ps
module dmc_setfreq (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Measured value and settings
  input  wire dmc_pkg::dmc_val_t statorFreq,
  input  wire dmc_pkg::dmc_val_t onThr,
  input  wire dmc_pkg::dmc_val_t offDelta,
  input  wire logic             stageEn,
  // Result
  output logic                  active
);
  import dmc_pkg::*;

  // Delta above threshold: no release level exists
  wire        noRelease = offDelta > onThr;
  wire [15:0] offThr    = onThr - offDelta;
  wire        above     = statorFreq > onThr;
  wire        below     = !noRelease && (statorFreq < offThr);

  always_ff @(posedge clk) begin
    if (srst || !stageEn)
      active <= 1'b0;
    else if (above)
      active <= 1'b1;
    else if (below)
      active <= 1'b0;
  end

  a_setfreq_on: assert property (@(posedge clk) disable iff (srst)
    stageEn && statorFreq > onThr |=> active)
    else $error("setting frequency not raised");
  a_setfreq_hold: assert property (@(posedge clk) disable iff (srst)
    active && stageEn && statorFreq >= onThr - offDelta && offDelta <= onThr |=> active)
    else $error("setting frequency dropped above release level");
  a_setfreq_latch: assert property (@(posedge clk) disable iff (srst)
    active && stageEn && offDelta > onThr |=> active)
    else $error("latched setting frequency released");
  a_setfreq_stage: assert property (@(posedge clk) disable iff (srst)
    !stageEn |=> !active)
    else $error("setting frequency high with stages off");
endmodule

/* hw/dmc_reached.sv */
`timescale 1ns/10ps
module dmc_reached (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Values
  input  wire dmc_pkg::dmc_val_t actual,
  input  wire dmc_pkg::dmc_val_t refVal,
  input  wire dmc_pkg::dmc_val_t rangeMax,
  input  wire dmc_pkg::dmc_val_t rangeMin,
  input  wire dmc_pkg::dmc_val_t maxDev,
  input  wire logic              enable,
  // Result
  output logic                   reached
);
  import dmc_pkg::*;

  // Scaled compare avoids a divider: |d| * 10000 <= range * dev
  wire [15:0] diff  = actual > refVal ? actual - refVal : refVal - actual;
  wire [15:0] range = rangeMax > rangeMin ? rangeMax - rangeMin : '0;
  wire [31:0] lhs   = 32'(diff) * PCT_SCALE;
  wire [31:0] rhs   = 32'(range) * 32'(maxDev);
  wire        inBand = lhs <= rhs;

  always_ff @(posedge clk) begin
    if (srst)
      reached <= 1'b0;
    else
      reached <= enable && inBand;
  end

  a_reached_band: assert property (@(posedge clk) disable iff (srst)
    enable && 32'(diff) * PCT_SCALE <= 32'(range) * 32'(maxDev) |=> reached)
    else $error("reached missing inside band");
  a_reached_out: assert property (@(posedge clk) disable iff (srst)
    !inBand || !enable |=> !reached)
    else $error("reached set outside band");
endmodule

/* hw/dmc_message_compare.sv */
`timescale 1ns/10ps
module dmc_message_compare (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Drive values
  input  wire dmc_pkg::dmc_val_t   statorFreq,
  input  wire dmc_pkg::dmc_val_t   refFreq,
  input  wire dmc_pkg::dmc_val_t   actFreq,
  input  wire dmc_pkg::dmc_val_t   maxFreq,
  input  wire dmc_pkg::dmc_val_t   minFreq,
  input  wire dmc_pkg::dmc_val_t   refPct,
  input  wire dmc_pkg::dmc_val_t   actPct,
  input  wire dmc_pkg::dmc_val_t   maxPct,
  input  wire dmc_pkg::dmc_val_t   minPct,
  input  wire logic                stageEn,
  input  wire logic                pctModeAvail,
  input  wire logic                extModPresent,
  // Source linking to drive functions
  input  wire dmc_pkg::dmc_code_t  linkCode,
  output logic                     linkVal,
  output dmc_pkg::dmc_src_t        sources,
  // Output terminals and interrupt
  output logic [dmc_pkg::NUM_OUT-1:0] digOut,
  output logic                     irq
);
  import dmc_pkg::*;

  dmc_outcfg_t         outCfg [NUM_OUT];
  dmc_val_t            setFreq;
  dmc_val_t            offDelta;
  dmc_val_t            maxDev;
  logic [NUM_EVT-1:0]  irqStat;
  logic [NUM_EVT-1:0]  irqMask;
  logic                dpWrite;
  logic [ADDR_W-1:0]   dpAddr;
  logic                setFreqSig;
  logic                freqReached;
  logic                pctReached;
  logic [NUM_OUT-1:0]  next_dig;

  // Pick a source by its linking code; registered sources break loops
  function automatic logic srcByCode(input dmc_code_t c, input dmc_src_t s);
    logic v;
    v = 1'b0;
    unique case (c)
      SRC_FREQ_RCH: v = s.freqReached;
      SRC_SETFREQ:  v = s.setFreq;
      SRC_PCT_RCH:  v = s.pctReached;
      SRC_DIG1:     v = s.digSig[0];
      SRC_DIG2:     v = s.digSig[1];
      SRC_DIG3:     v = s.digSig[2];
      SRC_EXT1:     v = s.digSig[OUT_EXT1];
      SRC_EXT2:     v = s.digSig[OUT_EXT1+1];
      default:      v = 1'b0;
    endcase
    return v;
  endfunction

  // Out-of-range writes saturate instead of wrapping
  function automatic dmc_val_t clampVal(input logic [31:0] v,
                                        input dmc_val_t lo, input dmc_val_t hi);
    dmc_val_t r;
    r = v[15:0];
    if (v > 32'(hi))
      r = hi;
    else if (v < 32'(lo))
      r = lo;
    return r;
  endfunction

  // Comparators
  dmc_setfreq u_setfreq (
    .clk        (clk),
    .srst       (srst),
    .statorFreq (statorFreq),
    .onThr      (setFreq),
    .offDelta   (offDelta),
    .stageEn    (stageEn),
    .active     (setFreqSig)
  );

  dmc_reached u_freq_rch (
    .clk      (clk),
    .srst     (srst),
    .actual   (actFreq),
    .refVal   (refFreq),
    .rangeMax (maxFreq),
    .rangeMin (minFreq),
    .maxDev   (maxDev),
    .enable   (1'b1),
    .reached  (freqReached)
  );

  dmc_reached u_pct_rch (
    .clk      (clk),
    .srst     (srst),
    .actual   (actPct),
    .refVal   (refPct),
    .rangeMax (maxPct),
    .rangeMin (minPct),
    .maxDev   (maxDev),
    .enable   (pctModeAvail),
    .reached  (pctReached)
  );

  // Per-output mode decode and linking
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    wire dmc_code_t md     = outCfg[i].mode;
    wire logic      inv    = md >= MODE_INV_BASE && md <= MODE_INV_LAST;
    wire dmc_code_t base   = inv ? md - MODE_INV_BASE : md;
    wire logic      legal  = md <= MODE_INV_LAST;
    wire logic      raw    = (base == MODE_ON)
                           | (base == MODE_SETFREQ  & setFreqSig)
                           | (base == MODE_FREQ_RCH & freqReached)
                           | (base == MODE_PCT_RCH  & pctReached & pctModeAvail);
    wire logic      modeV  = legal & (raw ^ inv);
    wire logic      linked = modeV | srcByCode(outCfg[i].link, sources);
    wire logic      fitted = (i < OUT_EXT1) || extModPresent;
    assign next_dig[i] = linked & fitted;
  end

  // Bus decode
  wire               addrPhase = hsel & hready & htrans[TRANS_ACT];
  wire [ADDR_W-1:0]  aAddr     = haddr[ADDR_W-1:0];
  wire [IDX_W-1:0]   aIdx      = aAddr[WORD_LSB +: IDX_W];
  wire [IDX_W-1:0]   dIdx      = dpAddr[WORD_LSB +: IDX_W];
  wire               aIsCfg    = aAddr < ADDR_SET_FREQ;
  wire               dIsCfg    = dpAddr < ADDR_SET_FREQ;
  wire               rdStat    = addrPhase & ~hwrite & (aAddr == ADDR_IRQ_STAT);
  wire [31:0]        rdMux     =
      aIsCfg                     ? 32'(outCfg[aIdx]) :
      aAddr == ADDR_SET_FREQ     ? 32'(setFreq) :
      aAddr == ADDR_OFF_DLT      ? 32'(offDelta) :
      aAddr == ADDR_MAX_DEV      ? 32'(maxDev) :
      aAddr == ADDR_STATUS       ? 32'(sources) :
      aAddr == ADDR_IRQ_STAT     ? 32'(irqStat) :
      aAddr == ADDR_IRQ_MASK     ? 32'(irqMask) : 32'h0000_0000;

  // Rising edges of the three message signals are the events
  wire [NUM_EVT-1:0] evtNew  = {pctReached, freqReached, setFreqSig};
  wire [NUM_EVT-1:0] evtOld  = {sources.pctReached, sources.freqReached, sources.setFreq};
  wire [NUM_EVT-1:0] evt     = evtNew & ~evtOld;
  // Event in the clearing cycle survives the read
  wire [NUM_EVT-1:0] next_irqStat = (rdStat ? '0 : irqStat) | evt;

  // Address phase capture
  always_ff @(posedge clk) begin
    if (srst) begin
      dpWrite <= 1'b0;
      dpAddr  <= '0;
    end else begin
      dpWrite <= addrPhase & hwrite;
      dpAddr  <= aAddr;
    end
  end

  // Zero-wait bus: read data latched at the address phase
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase && !hwrite)
        hrdata <= rdMux;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < NUM_OUT; k++)
        outCfg[k] <= '0;
      setFreq  <= SET_FREQ_RST;
      offDelta <= OFF_DELTA_RST;
      maxDev   <= DEV_RST;
      irqMask  <= '0;
    end else if (dpWrite) begin
      if (dIsCfg && dIdx < IDX_W'(NUM_OUT))
        outCfg[dIdx] <= hwdata[$bits(dmc_outcfg_t)-1:0];
      if (dpAddr == ADDR_SET_FREQ)
        setFreq <= clampVal(hwdata, '0, FREQ_MAX);
      if (dpAddr == ADDR_OFF_DLT)
        offDelta <= clampVal(hwdata, '0, FREQ_MAX);
      if (dpAddr == ADDR_MAX_DEV)
        maxDev <= clampVal(hwdata, DEV_MIN, DEV_MAX);
      if (dpAddr == ADDR_IRQ_MASK)
        irqMask <= hwdata[NUM_EVT-1:0];
    end
  end

  // Message outputs and sources
  always_ff @(posedge clk) begin
    if (srst) begin
      sources <= '0;
      digOut  <= '0;
      linkVal <= 1'b0;
      irqStat <= '0;
      irq     <= 1'b0;
    end else begin
      sources.setFreq     <= setFreqSig;
      sources.freqReached <= freqReached;
      sources.pctReached  <= pctReached & pctModeAvail;
      sources.digSig      <= next_dig;
      digOut              <= next_dig;
      linkVal             <= srcByCode(linkCode, sources);
      irqStat             <= next_irqStat;
      irq                 <= |(next_irqStat & irqMask);
    end
  end

  a_stage_off: assert property (@(posedge clk) disable iff (srst)
    !stageEn ##1 !$rose(stageEn) |=> !sources.setFreq)
    else $error("setting frequency source high with stages off");
  a_src_setfreq: assert property (@(posedge clk) disable iff (srst)
    ##1 sources.setFreq == $past(setFreqSig))
    else $error("source 164 does not follow comparator");
  a_ext_absent: assert property (@(posedge clk) disable iff (srst)
    !extModPresent |=> digOut[NUM_OUT-1:OUT_EXT1] == '0)
    else $error("extension output active without module");
  a_mode_four: assert property (@(posedge clk) disable iff (srst)
    outCfg[0] == dmc_outcfg_t'({SRC_NONE, MODE_SETFREQ}) |=> digOut[0] == $past(setFreqSig))
    else $error("mode 4 output wrong");
  a_mode_inv: assert property (@(posedge clk) disable iff (srst)
    outCfg[1] == dmc_outcfg_t'({SRC_NONE, MODE_INV_BASE + MODE_FREQ_RCH})
      |=> digOut[1] == !$past(freqReached))
    else $error("inverted mode output wrong");
  a_thr_range: assert property (@(posedge clk) disable iff (srst)
    setFreq <= FREQ_MAX && offDelta <= FREQ_MAX)
    else $error("threshold above limit");
  a_dev_range: assert property (@(posedge clk) disable iff (srst)
    maxDev >= DEV_MIN && maxDev <= DEV_MAX)
    else $error("deviation outside limits");
  a_pct_avail: assert property (@(posedge clk) disable iff (srst)
    !pctModeAvail |=> !sources.pctReached)
    else $error("percentage reached without configuration");
  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    irq == |($past(next_irqStat) & $past(irqMask)))
    else $error("interrupt level mismatch");
endmodule

/* bench/dmc_drive_model.sv */
`timescale 1ns/10ps
module dmc_drive_model #(
  parameter dmc_pkg::dmc_val_t FMAX = 16'h1388,
  parameter dmc_pkg::dmc_val_t PMAX = 16'h2710
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Commanded values
  input  wire dmc_pkg::dmc_val_t cmdStator,
  input  wire dmc_pkg::dmc_val_t cmdAct,
  input  wire dmc_pkg::dmc_val_t cmdActPct,
  // Drive values
  output dmc_pkg::dmc_val_t      statorFreq,
  output dmc_pkg::dmc_val_t      actFreq,
  output dmc_pkg::dmc_val_t      actPct,
  output dmc_pkg::dmc_val_t      maxFreq,
  output dmc_pkg::dmc_val_t      minFreq,
  output dmc_pkg::dmc_val_t      maxPct,
  output dmc_pkg::dmc_val_t      minPct
);
  import dmc_pkg::*;
  // Control loop lags its command by one cycle
  always_ff @(posedge clk) begin
    statorFreq <= srst ? 16'h0000 : cmdStator;
    actFreq    <= srst ? 16'h0000 : cmdAct;
    actPct     <= srst ? 16'h0000 : cmdActPct;
  end
  assign maxFreq = FMAX;
  assign minFreq = 16'h0000;
  assign maxPct  = PMAX;
  assign minPct  = 16'h0000;
endmodule

/* bench/dmc_message_compare_tb.sv */
`timescale 1ns/10ps
module dmc_message_compare_tb;
  import dmc_pkg::*;
  typedef struct { int id; logic [31:0] e; string nm; } dmc_note_t;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0, stageEn = 0, pctModeAvail = 0;
  logic extModPresent = 0, hreadyout, hresp, linkVal, irq;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h896DEA71;
  dmc_val_t    cmdStator = 0, cmdAct = 0, cmdActPct = 0, refFreq = 0, refPct = 0;
  dmc_val_t    statorFreq, actFreq, actPct, maxFreq, minFreq, maxPct, minPct;
  dmc_code_t   linkCode = SRC_NONE;
  dmc_src_t    sources;
  logic [NUM_OUT-1:0] digOut;
  logic [7:0]  srcBits;
  int n_mismatch = 0, total_checks = 0, thr;
  logic sf;
  dmc_note_t q[$];
  event look;
  dmc_code_t codes[9] = '{SRC_SETFREQ, SRC_DIG1, SRC_DIG2, SRC_DIG3, SRC_EXT1,
                          SRC_EXT2, SRC_FREQ_RCH, SRC_PCT_RCH, SRC_NONE};
  logic lexp[9] = '{1, 1, 1, 0, 0, 1, 1, 0, 0};
  assign srcBits = sources;
  always #25 clk = ~clk;

  dmc_drive_model DRV (.clk(clk), .srst(srst), .cmdStator(cmdStator), .cmdAct(cmdAct),
    .cmdActPct(cmdActPct), .statorFreq(statorFreq), .actFreq(actFreq), .actPct(actPct),
    .maxFreq(maxFreq), .minFreq(minFreq), .maxPct(maxPct), .minPct(minPct));
  dmc_message_compare DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .statorFreq(statorFreq),
    .refFreq(refFreq), .actFreq(actFreq), .maxFreq(maxFreq), .minFreq(minFreq),
    .refPct(refPct), .actPct(actPct), .maxPct(maxPct), .minPct(minPct),
    .stageEn(stageEn), .pctModeAvail(pctModeAvail), .extModPresent(extModPresent),
    .linkCode(linkCode), .linkVal(linkVal), .sources(sources), .digOut(digOut),
    .irq(irq));

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] obs(int id);
    if (id == 0) return rd;
    if (id < 6) return {31'h0, digOut[id-1]};
    if (id < 20) return {31'h0, srcBits[id-10]};
    if (id == 20) return {31'h0, linkVal};
    if (id == 22) return {31'h0, hresp};
    return {31'h0, irq};
  endfunction
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkv(int id, logic [31:0] e, string nm);
    q.push_back('{id, e, nm});
    -> look;
  endtask
  // Monitor: every queued note is checked at once against the signal it names as it shows now
  initial forever begin
    @(look);
    while (q.size() > 0) begin
      dmc_note_t n;
      n = q.pop_front();
      check(n.nm, obs(n.id), n.e);
    end
  end

  // No wait limit here: only the watchdog ends a stalled transfer
  task automatic wait_rdy();
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    hsel <= 0;
  endtask
  task automatic rdc(logic [11:0] a, logic [31:0] e);
    bus(0, a, 32'h0);
    chkv(0, e, "rdata");
    chkv(22, 32'h0000_0000, "hresp");
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic setS(dmc_val_t v);
    @(posedge clk);
    cmdStator <= v;
    settle();
  endtask
  task automatic stage(logic v);
    @(posedge clk);
    stageEn <= v;
    settle();
  endtask
  task automatic chkSf(logic e);
    chkv(1, e, "dig1");
    chkv(15, e, "srcSetFreq");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rdc(ADDR_SET_FREQ, 32'h0000_012C);
    rdc(ADDR_OFF_DLT, 32'h0000_00C8);
    rdc(ADDR_MAX_DEV, 32'h0000_01F4);
    rdc(12'h100, 32'h0000_0000);
    bus(1'b1, ADDR_SET_FREQ, 32'h0000_FFFF);
    rdc(ADDR_SET_FREQ, {16'h0000, FREQ_MAX});
    bus(1'b1, ADDR_MAX_DEV, 32'h0000_0000);
    rdc(ADDR_MAX_DEV, 32'h0000_0001);
    bus(1'b1, ADDR_MAX_DEV, 32'h0000_01F4);
    bus(1'b1, ADDR_SET_FREQ, 32'h0000_012C);
    bus(1'b1, ADDR_OUT_CFG0, {24'h00_0000, MODE_SETFREQ});
    stage(1'b1);
    setS(16'h012C);
    chkSf(1'b0);
    setS(16'h012D);
    chkSf(1'b1);
    setS(16'h0064);
    chkSf(1'b1);
    setS(16'h0063);
    chkSf(1'b0);
    setS(16'h0190);
    stage(1'b0);
    chkSf(1'b0);
    stage(1'b1);
    bus(1'b1, ADDR_OFF_DLT, 32'h0000_0190);
    setS(16'h0000);
    chkSf(1'b1);
    stage(1'b0);
    bus(1'b1, ADDR_OFF_DLT, 32'h0000_00C8);
    stage(1'b1);
    sf = 1'b0;
    thr = int'(SET_FREQ_RST);
    // Random stator frequencies against a reference hysteresis model
    repeat (24) begin
      seed = lfsr(seed);
      setS(dmc_val_t'(seed % 32'h0000_0258));
      if (int'(cmdStator) > thr)
        sf = 1'b1;
      else if (int'(cmdStator) < thr - int'(OFF_DELTA_RST))
        sf = 1'b0;
      chkSf(sf);
    end
    setS(16'h0190);
    @(posedge clk);
    refFreq <= 16'h03E8;
    bus(1'b1, 12'h004, {24'h00_0000, MODE_FREQ_RCH});
    foreach (codes[i]) begin
      if (i < 4) begin
        @(posedge clk);
        cmdAct <= (i < 2) ? 16'(16'h04E2 + i) : 16'(16'h02F0 - i);
        settle();
        chkv(2, (i % 2) == 0, "dig2");
        chkv(16, (i % 2) == 0, "srcFreqRch");
      end
    end
    // Inverted mode 5: high off the band, low once inside it
    bus(1'b1, 12'h004, {24'h00_0000, MODE_INV_BASE + MODE_FREQ_RCH});
    settle();
    chkv(2, 1, "dig2Inv");
    @(posedge clk);
    cmdAct <= 16'h03E8;
    settle();
    chkv(2, 0, "dig2Inv");
    @(posedge clk);
    refPct <= 16'h0BB8;
    pctModeAvail <= 1'b1;
    cmdActPct <= 16'h0DAC;
    bus(1'b1, 12'h008, {24'h00_0000, MODE_PCT_RCH});
    settle();
    chkv(3, 1, "dig3");
    chkv(17, 1, "srcPctRch");
    @(posedge clk);
    cmdActPct <= 16'h0DAD;
    settle();
    chkv(3, 0, "dig3");
    @(posedge clk);
    cmdActPct <= 16'h0BB8;
    pctModeAvail <= 1'b0;
    settle();
    chkv(3, 0, "dig3");
    @(posedge clk);
    cmdActPct <= 16'h0DAD;
    bus(1'b1, 12'h00C, {24'h00_0000, MODE_INV_BASE + MODE_SETFREQ});
    bus(1'b1, 12'h010, {24'h00_0000, MODE_ON});
    bus(1'b1, 12'h004, {16'h0000, SRC_DIG1, MODE_OFF});
    settle();
    chkv(5, 0, "ext2Absent");
    chkv(4, 0, "ext1Absent");
    @(posedge clk);
    extModPresent <= 1'b1;
    settle();
    chkv(4, 0, "ext1Inv");
    chkv(5, 1, "ext2On");
    chkv(2, 1, "dig2Linked");
    foreach (codes[i]) begin
      @(posedge clk);
      linkCode <= codes[i];
      settle();
      chkv(20, lexp[i], "linkVal");
    end
    setS(16'h0000);
    stage(1'b0);
    chkv(4, 1, "ext1Inv");
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    // All three messages have risen since reset and nothing cleared them
    rdc(ADDR_IRQ_STAT, 32'h0000_0007);
    settle();
    chkv(21, 0, "irqIdle");
    setS(16'h0190);
    stage(1'b1);
    chkv(21, 1, "irqSet");
    rdc(ADDR_IRQ_STAT, 32'h0000_0001);
    settle();
    chkv(21, 0, "irqCleared");
    #1;
    final_report();
  end
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
endmodule
